// *** adcr_defines.vh ***
`ifndef ADCR_DEFINES_VH
`define ADCR_DEFINES_VH

// Register word offsets on the primary serial interface.
`define ADCR_ADDR_ANGLE_CAP 8'h04
`define ADCR_ADDR_DIAG 8'h05
`define ADCR_ADDR_ALG 8'h06

// Field positions inside the diagnostic and capture words.
`define ADCR_HI_MSB 31
`define ADCR_HI_LSB 16
`define ADCR_LO_MSB 15
`define ADCR_LO_LSB 0

// Bit positions in the algorithm-enable word.
`define ADCR_BIT_RD 27
`define ADCR_BIT_REF 26
`define ADCR_BIT_BYP 25
`define ADCR_BIT_SS 24
`define ADCR_BIT_INV 22
`define ADCR_BIT_DIR 21
`define ADCR_BIT_SEG 20
`define ADCR_BIT_HRM 19
`define ADCR_BIT_PRE 18
`define ADCR_BIT_FI 16

// Writable bits of the algorithm-enable word and its reset value.
`define ADCR_ALG_WMASK 32'h0f7fffff
`define ADCR_ALG_RESET 32'h00000000
`define ADCR_WORD_RESET 32'h00000000
`define ADCR_HALF_RESET 16'h0000

// Self-test result codes.
`define ADCR_RES_PASS 16'h0000
`define ADCR_RES_TIMEOUT 16'h00ff

// Half of a 65,536-count turn, for the rotate step.
`define ADCR_HALF_TURN 16'h8000

// Sixteen segments of 22.5 degrees: the top four angle bits.
`define ADCR_SEG_SHIFT 12
`define ADCR_SEG_IDX_W 4

`endif

// *** adcr_oor_check.v ***
`timescale 1ns/1ps
`default_nettype none

// Limit checker shared by the angle and the magnetic field paths.
module adcr_oor_check #(
    parameter W = 16
) (
    input wire clk,
    input wire rst_n,
    input wire enable,
    input wire sample_valid,
    input wire [W-1:0] sample,
    input wire [W-1:0] upper_limit,
    input wire [W-1:0] lower_limit,
    output reg capture,
    output reg over_flag,
    output reg under_flag,
    output reg [W-1:0] captured
);

    wire over_d;
    wire under_d;

    // A sample over the limit is never also reported as under.
    assign over_d = enable && sample_valid && (sample > upper_limit);
    assign under_d = enable && sample_valid && !over_d && (sample < lower_limit);

    // Registered, so the parent may pass them straight to pins.
    always @(posedge clk) begin
        if (!rst_n) begin
            capture <= 1'b0;
            over_flag <= 1'b0;
            under_flag <= 1'b0;
            captured <= {W{1'b0}};
        end else begin
            capture <= over_d || under_d;
            over_flag <= over_d;
            under_flag <= under_d;
            if (over_d || under_d) begin
                captured <= sample;
            end
        end
    end

endmodule // adcr_oor_check

`default_nettype wire

// *** adcr_out_stage.v ***
`timescale 1ns/1ps
`default_nettype none

`include "adcr_defines.vh"

// Final angle steps after linearization: direction, inversion, half-turn rotation.
module adcr_out_stage #(
    parameter W = 16
) (
    input wire clk,
    input wire rst_n,
    input wire in_valid,
    input wire [W-1:0] in_angle,
    input wire reverse_dir,
    input wire invert,
    input wire rotate_half,
    input wire [W-1:0] clamp_upper,
    output reg out_valid,
    output reg [W-1:0] out_angle
);

    wire [W-1:0] dir_angle;
    wire [W-1:0] inv_angle;
    wire [W-1:0] rot_angle;

    // Negation mirrors the sense of rotation; all sums wrap modulo one full turn.
    assign dir_angle = reverse_dir ? ({W{1'b0}} - in_angle) : in_angle;
    assign inv_angle = invert ? (clamp_upper - dir_angle) : dir_angle;
    assign rot_angle = rotate_half ? (inv_angle + `ADCR_HALF_TURN) : inv_angle;

    // One register stage keeps the path short at the core clock rate.
    always @(posedge clk) begin
        if (!rst_n) begin
            out_valid <= 1'b0;
            out_angle <= {W{1'b0}};
        end else begin
            out_valid <= in_valid;
            if (in_valid) begin
                out_angle <= rot_angle;
            end
        end
    end

endmodule // adcr_out_stage

`default_nettype wire

// *** adcr_regs.v ***
`timescale 1ns/1ps
`default_nettype none

`include "adcr_defines.vh"

//
// Contract
// - Out-of-limit unclamped angle is stored in the angle capture field bits 15:0.
// - Upper angle violation pulses angle-high flag; lower violation pulses angle-low flag.
// - Self-test writes bits 31:16: zero pass, 0xFF timeout, else failing element count.
// - Any self-test fault pulses the self-test fault flag.
// - Out-of-limit field strength is stored in diagnostic word bits 15:0.
// - Upper field violation pulses field-high flag; lower violation pulses field-low flag.
// - Bit 27 adds half a turn to the final angle, wrapping, as last step.
// - Bit 26 picks eccentricity reference: 0 external encoder, 1 internal angle.
// - Segmented linearization uses reference segments of 22.5 degrees.
// - Bit 25 with bit 20 applies segment offset but skips segment coefficients.
// - Bit 24 gates angle limit checks, clamps and gain stage.
// - Bit 22 outputs upper clamp minus angle; clear outputs angle unchanged.
// - Bit 21 sets post-linearization direction: 0 clockwise, 1 counterclockwise.
// - Bit 20 enables segmented linearization when set.
// - Initialization loads select, bypass, short-stroke, invert, direction bits from NVM.
// - Angles use 65,536 counts per full turn in a 16-bit word.
// - A separate pre-linearization direction bit exists beside the post one.
module adcr_regs #(
    parameter W = 16
) (
    input wire CLK,
    input wire RST_N,
    // Register port of the primary serial interface.
    input wire [7:0] REG_ADDR,
    input wire REG_WR,
    input wire [31:0] REG_WDATA,
    input wire REG_RD,
    output reg [31:0] REG_RDATA,
    output reg REG_RVALID,
    // Non-volatile image applied at initialization.
    input wire NVM_LOAD,
    input wire NVM_SEGLIN_REFERENCE_SELECT,
    input wire NVM_SEGLIN_COEFF_BYPASS,
    input wire NVM_SHORT_STROKE,
    input wire NVM_INVERT_OUTPUT,
    input wire NVM_POST_LIN_DIRECTION,
    input wire NVM_PRE_LIN_DIRECTION,
    // Limits held in neighbouring registers.
    input wire [W-1:0] ANGLE_UPPER_LIMIT,
    input wire [W-1:0] ANGLE_LOWER_LIMIT,
    input wire [W-1:0] CLAMP_UPPER,
    input wire [W-1:0] FIELD_UPPER_LIMIT,
    input wire [W-1:0] FIELD_LOWER_LIMIT,
    // Samples from the angle and field paths.
    input wire ANGLE_VALID,
    input wire [W-1:0] ANGLE_UNCLAMPED,
    input wire FIELD_VALID,
    input wire [W-1:0] FIELD_STRENGTH,
    input wire LIN_IN_VALID,
    input wire [W-1:0] LIN_IN_ANGLE,
    input wire POST_LIN_VALID,
    input wire [W-1:0] POST_LIN_ANGLE,
    // Self-test completion report.
    input wire SELFTEST_DONE,
    input wire SELFTEST_TIMEOUT,
    input wire [W-1:0] SELFTEST_FAIL_COUNT,
    // Error flag set pulses towards the error registers.
    output reg ANGLE_HIGH_FLAG,
    output reg ANGLE_LOW_FLAG,
    output reg FIELD_HIGH_FLAG,
    output reg FIELD_LOW_FLAG,
    output reg SELFTEST_FAULT_FLAG,
    // Algorithm controls.
    output reg ROTATE_HALF_TURN,
    output reg SEGLIN_REFERENCE_SELECT,
    output reg SEGLIN_APPLY_OFFSET,
    output reg SEGLIN_APPLY_COEFFS,
    output reg SHORT_STROKE,
    output reg INVERT_OUTPUT,
    output reg POST_LIN_DIRECTION,
    output reg SEGLIN_ENABLE,
    output reg HARMONIC_LIN_ENABLE,
    output reg PRE_LIN_DIRECTION,
    output reg FILTER_ENABLE,
    output reg [W-1:0] OUTPUT_ZERO_SHIFT,
    // Segment index and final angle.
    output reg SEGMENT_VALID,
    output reg [`ADCR_SEG_IDX_W-1:0] SEGMENT_INDEX,
    output reg FINAL_VALID,
    output reg [W-1:0] FINAL_ANGLE
);

    reg [31:0] alg_q;
    reg [31:0] alg_d;
    reg [W-1:0] temp_cap_q;
    reg [W-1:0] angle_cap_q;
    reg [W-1:0] angle_cap_d;
    reg [W-1:0] selftest_result_q;
    reg [W-1:0] selftest_result_d;
    reg [W-1:0] field_cap_q;
    reg [W-1:0] field_cap_d;
    reg [31:0] rdata_d;

    wire wr_angle_cap;
    wire wr_diag;
    wire wr_alg;
    wire short_stroke_en;
    wire ang_capture;
    wire ang_high;
    wire ang_low;
    wire [W-1:0] ang_value;
    wire fld_capture;
    wire fld_high;
    wire fld_low;
    wire [W-1:0] fld_value;
    wire res_fault;
    wire [W-1:0] res_code;
    wire out_valid;
    wire [W-1:0] out_angle;

    // Address decode for the three words of this bank.
    assign wr_angle_cap = REG_WR && (REG_ADDR == `ADCR_ADDR_ANGLE_CAP);
    assign wr_diag = REG_WR && (REG_ADDR == `ADCR_ADDR_DIAG);
    assign wr_alg = REG_WR && (REG_ADDR == `ADCR_ADDR_ALG);

    assign short_stroke_en = alg_q[`ADCR_BIT_SS];

    // The angle limits only apply in short-stroke mode.
    adcr_oor_check #(
        .W(W)
    ) u_angle_check (
        .clk(CLK),
        .rst_n(RST_N),
        .enable(short_stroke_en),
        .sample_valid(ANGLE_VALID),
        .sample(ANGLE_UNCLAMPED),
        .upper_limit(ANGLE_UPPER_LIMIT),
        .lower_limit(ANGLE_LOWER_LIMIT),
        .capture(ang_capture),
        .over_flag(ang_high),
        .under_flag(ang_low),
        .captured(ang_value)
    );

    // The field limits are checked in every mode.
    adcr_oor_check #(
        .W(W)
    ) u_field_check (
        .clk(CLK),
        .rst_n(RST_N),
        .enable(1'b1),
        .sample_valid(FIELD_VALID),
        .sample(FIELD_STRENGTH),
        .upper_limit(FIELD_UPPER_LIMIT),
        .lower_limit(FIELD_LOWER_LIMIT),
        .capture(fld_capture),
        .over_flag(fld_high),
        .under_flag(fld_low),
        .captured(fld_value)
    );

    // Final angle steps are driven by the live enable bits.
    adcr_out_stage #(
        .W(W)
    ) u_out_stage (
        .clk(CLK),
        .rst_n(RST_N),
        .in_valid(POST_LIN_VALID),
        .in_angle(POST_LIN_ANGLE),
        .reverse_dir(alg_q[`ADCR_BIT_DIR]),
        .invert(alg_q[`ADCR_BIT_INV]),
        .rotate_half(alg_q[`ADCR_BIT_RD]),
        .clamp_upper(CLAMP_UPPER),
        .out_valid(out_valid),
        .out_angle(out_angle)
    );

    // Self-test code: a timeout overrides any element count.
    assign res_code = SELFTEST_TIMEOUT ? `ADCR_RES_TIMEOUT : SELFTEST_FAIL_COUNT;
    assign res_fault = SELFTEST_DONE && (res_code != `ADCR_RES_PASS);

    // Enable word: the NVM load overrides a same-cycle write on the six bits it loads.
    // Masking keeps the reserved bits reading zero.
    always @* begin
        alg_d = alg_q;
        if (wr_alg) begin
            alg_d = REG_WDATA & `ADCR_ALG_WMASK;
        end
        if (NVM_LOAD) begin
            alg_d[`ADCR_BIT_REF] = NVM_SEGLIN_REFERENCE_SELECT;
            alg_d[`ADCR_BIT_BYP] = NVM_SEGLIN_COEFF_BYPASS;
            alg_d[`ADCR_BIT_SS] = NVM_SHORT_STROKE;
            alg_d[`ADCR_BIT_INV] = NVM_INVERT_OUTPUT;
            alg_d[`ADCR_BIT_DIR] = NVM_POST_LIN_DIRECTION;
            alg_d[`ADCR_BIT_PRE] = NVM_PRE_LIN_DIRECTION;
        end
    end

    // Capture fields hold until a new event or a write; the event wins a tie.
    // The written field that races a capture is lost, so no event is missed.
    always @* begin
        angle_cap_d = angle_cap_q;
        field_cap_d = field_cap_q;
        selftest_result_d = selftest_result_q;
        if (wr_angle_cap) begin
            angle_cap_d = REG_WDATA[`ADCR_LO_MSB:`ADCR_LO_LSB];
        end
        if (ang_capture) begin
            angle_cap_d = ang_value;
        end
        if (wr_diag) begin
            field_cap_d = REG_WDATA[`ADCR_LO_MSB:`ADCR_LO_LSB];
            selftest_result_d = REG_WDATA[`ADCR_HI_MSB:`ADCR_HI_LSB];
        end
        if (fld_capture) begin
            field_cap_d = fld_value;
        end
        if (SELFTEST_DONE) begin
            selftest_result_d = res_code;
        end
    end

    // Read multiplexer; unmapped addresses read as zero.
    always @* begin
        case (REG_ADDR)
            `ADCR_ADDR_ANGLE_CAP: begin
                rdata_d = {temp_cap_q, angle_cap_q};
            end
            `ADCR_ADDR_DIAG: begin
                rdata_d = {selftest_result_q, field_cap_q};
            end
            `ADCR_ADDR_ALG: begin
                rdata_d = alg_q;
            end
            default: begin
                rdata_d = `ADCR_WORD_RESET;
            end
        endcase
    end

    // Register storage and the read answer, one cycle after the strobe.
    always @(posedge CLK) begin
        if (!RST_N) begin
            alg_q <= `ADCR_ALG_RESET;
            temp_cap_q <= `ADCR_HALF_RESET;
            angle_cap_q <= `ADCR_HALF_RESET;
            field_cap_q <= `ADCR_HALF_RESET;
            selftest_result_q <= `ADCR_HALF_RESET;
            REG_RDATA <= `ADCR_WORD_RESET;
            REG_RVALID <= 1'b0;
        end else begin
            alg_q <= alg_d;
            angle_cap_q <= angle_cap_d;
            field_cap_q <= field_cap_d;
            selftest_result_q <= selftest_result_d;
            if (wr_angle_cap) begin
                temp_cap_q <= REG_WDATA[`ADCR_HI_MSB:`ADCR_HI_LSB];
            end
            REG_RVALID <= REG_RD;
            if (REG_RD) begin
                REG_RDATA <= rdata_d;
            end
        end
    end

    // Error flag pulses, aligned with the capture they belong to.
    always @(posedge CLK) begin
        if (!RST_N) begin
            ANGLE_HIGH_FLAG <= 1'b0;
            ANGLE_LOW_FLAG <= 1'b0;
            FIELD_HIGH_FLAG <= 1'b0;
            FIELD_LOW_FLAG <= 1'b0;
            SELFTEST_FAULT_FLAG <= 1'b0;
        end else begin
            ANGLE_HIGH_FLAG <= ang_high;
            ANGLE_LOW_FLAG <= ang_low;
            FIELD_HIGH_FLAG <= fld_high;
            FIELD_LOW_FLAG <= fld_low;
            SELFTEST_FAULT_FLAG <= res_fault;
        end
    end

    // Control outputs mirror the enable word one cycle later.
    // The extra stage costs a cycle of latency but keeps every pin on a flop.
    always @(posedge CLK) begin
        if (!RST_N) begin
            ROTATE_HALF_TURN <= 1'b0;
            SEGLIN_REFERENCE_SELECT <= 1'b0;
            SEGLIN_APPLY_OFFSET <= 1'b0;
            SEGLIN_APPLY_COEFFS <= 1'b0;
            SHORT_STROKE <= 1'b0;
            INVERT_OUTPUT <= 1'b0;
            POST_LIN_DIRECTION <= 1'b0;
            SEGLIN_ENABLE <= 1'b0;
            HARMONIC_LIN_ENABLE <= 1'b0;
            PRE_LIN_DIRECTION <= 1'b0;
            FILTER_ENABLE <= 1'b0;
            OUTPUT_ZERO_SHIFT <= `ADCR_HALF_RESET;
        end else begin
            ROTATE_HALF_TURN <= alg_q[`ADCR_BIT_RD];
            SEGLIN_REFERENCE_SELECT <= alg_q[`ADCR_BIT_REF];
            SEGLIN_APPLY_OFFSET <= alg_q[`ADCR_BIT_SEG];
            SEGLIN_APPLY_COEFFS <= alg_q[`ADCR_BIT_SEG] && !alg_q[`ADCR_BIT_BYP];
            SHORT_STROKE <= alg_q[`ADCR_BIT_SS];
            INVERT_OUTPUT <= alg_q[`ADCR_BIT_INV];
            POST_LIN_DIRECTION <= alg_q[`ADCR_BIT_DIR];
            SEGLIN_ENABLE <= alg_q[`ADCR_BIT_SEG];
            HARMONIC_LIN_ENABLE <= alg_q[`ADCR_BIT_HRM];
            PRE_LIN_DIRECTION <= alg_q[`ADCR_BIT_PRE];
            FILTER_ENABLE <= alg_q[`ADCR_BIT_FI];
            OUTPUT_ZERO_SHIFT <= alg_q[`ADCR_LO_MSB:`ADCR_LO_LSB];
        end
    end

    // Segment index: each segment is 4096 counts of a 65,536-count turn.
    // Flagged valid only while segmented linearization is on; the index follows every input sample.
    always @(posedge CLK) begin
        if (!RST_N) begin
            SEGMENT_VALID <= 1'b0;
            SEGMENT_INDEX <= {`ADCR_SEG_IDX_W{1'b0}};
        end else begin
            SEGMENT_VALID <= LIN_IN_VALID && alg_q[`ADCR_BIT_SEG];
            if (LIN_IN_VALID) begin
                SEGMENT_INDEX <= LIN_IN_ANGLE[W-1:W-`ADCR_SEG_IDX_W];
            end
        end
    end

    // Final angle from the output stage, re-registered onto the pins.
    always @(posedge CLK) begin
        if (!RST_N) begin
            FINAL_VALID <= 1'b0;
            FINAL_ANGLE <= `ADCR_HALF_RESET;
        end else begin
            FINAL_VALID <= out_valid;
            if (out_valid) begin
                FINAL_ANGLE <= out_angle;
            end
        end
    end

endmodule // adcr_regs

`default_nettype wire

// *** adcr_regs_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none

`include "adcr_defines.vh"

// Checks the register bank at its ports, on the core clock.
module adcr_regs_chk #(
    parameter W = 16
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_RD,
    input wire logic [31:0] REG_RDATA,
    input wire logic NVM_LOAD,
    input wire logic NVM_SHORT_STROKE,
    input wire logic NVM_INVERT_OUTPUT,
    input wire logic [W-1:0] ANGLE_UPPER_LIMIT,
    input wire logic [W-1:0] ANGLE_LOWER_LIMIT,
    input wire logic [W-1:0] FIELD_UPPER_LIMIT,
    input wire logic [W-1:0] FIELD_LOWER_LIMIT,
    input wire logic ANGLE_VALID,
    input wire logic [W-1:0] ANGLE_UNCLAMPED,
    input wire logic FIELD_VALID,
    input wire logic [W-1:0] FIELD_STRENGTH,
    input wire logic LIN_IN_VALID,
    input wire logic [W-1:0] LIN_IN_ANGLE,
    input wire logic POST_LIN_VALID,
    input wire logic SELFTEST_DONE,
    input wire logic SELFTEST_TIMEOUT,
    input wire logic [W-1:0] SELFTEST_FAIL_COUNT,
    input wire logic ANGLE_HIGH_FLAG,
    input wire logic ANGLE_LOW_FLAG,
    input wire logic FIELD_HIGH_FLAG,
    input wire logic FIELD_LOW_FLAG,
    input wire logic SELFTEST_FAULT_FLAG,
    input wire logic SEGLIN_APPLY_OFFSET,
    input wire logic SEGLIN_APPLY_COEFFS,
    input wire logic SHORT_STROKE,
    input wire logic INVERT_OUTPUT,
    input wire logic SEGLIN_ENABLE,
    input wire logic SEGMENT_VALID,
    input wire logic [`ADCR_SEG_IDX_W-1:0] SEGMENT_INDEX,
    input wire logic FINAL_VALID
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    // Write, idle cycle, then read of the enable word.
    sequence s_alg_wr_rd;
        (REG_WR && REG_ADDR == `ADCR_ADDR_ALG) ##1 (!REG_WR && !NVM_LOAD)
            ##1 (REG_RD && !REG_WR && !NVM_LOAD && REG_ADDR == `ADCR_ADDR_ALG);
    endsequence
    sequence s_ang_over;
        (ANGLE_VALID && ANGLE_UNCLAMPED > ANGLE_UPPER_LIMIT) ##1 SHORT_STROKE;
    endsequence
    sequence s_ang_under;
        (ANGLE_VALID && ANGLE_UNCLAMPED < ANGLE_LOWER_LIMIT
            && ANGLE_UNCLAMPED <= ANGLE_UPPER_LIMIT) ##1 SHORT_STROKE;
    endsequence

    AST_ALG_MASK:
        assert property (s_alg_wr_rd |-> ##1 REG_RDATA == ($past(REG_WDATA, 3) & 32'h0f7fffff))
        else $error("enable word read does not match masked write");
    AST_ANG_HIGH:
        assert property (s_ang_over |-> ##1 ANGLE_HIGH_FLAG && !ANGLE_LOW_FLAG)
        else $error("angle high flag wrong");
    AST_ANG_LOW:
        assert property (s_ang_under |-> ##1 ANGLE_LOW_FLAG && !ANGLE_HIGH_FLAG)
        else $error("angle low flag wrong");
    AST_ANG_GATE:
        assert property (ANGLE_VALID ##1 !SHORT_STROKE |-> ##1 !ANGLE_HIGH_FLAG && !ANGLE_LOW_FLAG)
        else $error("angle flag raised with short stroke off");
    AST_FLD_HIGH:
        assert property (FIELD_VALID && FIELD_STRENGTH > FIELD_UPPER_LIMIT |-> ##2 FIELD_HIGH_FLAG)
        else $error("field high flag missing");
    AST_FLD_LOW:
        assert property (FIELD_VALID && FIELD_STRENGTH < FIELD_LOWER_LIMIT
            && FIELD_STRENGTH <= FIELD_UPPER_LIMIT |-> ##2 FIELD_LOW_FLAG && !FIELD_HIGH_FLAG)
        else $error("field low flag wrong");
    AST_RES_FLAG:
        assert property (SELFTEST_DONE |-> ##1 SELFTEST_FAULT_FLAG ==
            ($past(SELFTEST_TIMEOUT) || $past(SELFTEST_FAIL_COUNT) != 0))
        else $error("self-test fault flag wrong");
    AST_FINAL_LAT:
        assert property (POST_LIN_VALID |-> ##2 FINAL_VALID)
        else $error("final angle not delivered two cycles later");
    AST_SEG:
        assert property (LIN_IN_VALID |-> ##1 (SEGMENT_VALID == SEGLIN_ENABLE
            && SEGMENT_INDEX == 4'($past(LIN_IN_ANGLE) >> 12)))
        else $error("segment index or valid wrong");
    AST_SEG_APPLY:
        assert property (SEGLIN_APPLY_OFFSET == SEGLIN_ENABLE
            && (!SEGLIN_APPLY_COEFFS || SEGLIN_ENABLE))
        else $error("segment offset or coefficient apply wrong");
    AST_NVM:
        assert property (NVM_LOAD ##1 !REG_WR |-> ##1 SHORT_STROKE == $past(NVM_SHORT_STROKE, 2)
            && INVERT_OUTPUT == $past(NVM_INVERT_OUTPUT, 2))
        else $error("initial load not applied");
endmodule // adcr_regs_chk

bind adcr_regs adcr_regs_chk #(.W(W)) chk (.*);

`default_nettype wire

// *** adcr_regs_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

`include "adcr_defines.vh"

module adcr_regs_tb_top;
    logic CLK, RST_N, REG_WR, REG_RD, REG_RVALID, NVM_LOAD, ANGLE_VALID, FIELD_VALID;
    logic NVM_SEGLIN_REFERENCE_SELECT, NVM_SEGLIN_COEFF_BYPASS, NVM_SHORT_STROKE;
    logic NVM_INVERT_OUTPUT, NVM_POST_LIN_DIRECTION, NVM_PRE_LIN_DIRECTION, LIN_IN_VALID;
    logic POST_LIN_VALID, SELFTEST_DONE, SELFTEST_TIMEOUT, ANGLE_HIGH_FLAG, ANGLE_LOW_FLAG;
    logic FIELD_HIGH_FLAG, FIELD_LOW_FLAG, SELFTEST_FAULT_FLAG, ROTATE_HALF_TURN, SHORT_STROKE;
    logic SEGLIN_REFERENCE_SELECT, SEGLIN_APPLY_OFFSET, SEGLIN_APPLY_COEFFS, INVERT_OUTPUT;
    logic POST_LIN_DIRECTION, SEGLIN_ENABLE, HARMONIC_LIN_ENABLE, PRE_LIN_DIRECTION;
    logic FILTER_ENABLE, SEGMENT_VALID, FINAL_VALID;
    logic [7:0] REG_ADDR;
    logic [31:0] REG_WDATA, REG_RDATA;
    logic [3:0] SEGMENT_INDEX;
    logic [15:0] ANGLE_UPPER_LIMIT, ANGLE_LOWER_LIMIT, CLAMP_UPPER, FIELD_UPPER_LIMIT;
    logic [15:0] FIELD_LOWER_LIMIT, ANGLE_UNCLAMPED, FIELD_STRENGTH, LIN_IN_ANGLE;
    logic [15:0] POST_LIN_ANGLE, SELFTEST_FAIL_COUNT, OUTPUT_ZERO_SHIFT, FINAL_ANGLE;
    int err_count = 0;
    int checks_done = 0;
    // All single-bit control outputs, for one compare.
    wire [10:0] ctl = {ROTATE_HALF_TURN, SEGLIN_REFERENCE_SELECT, SEGLIN_APPLY_OFFSET,
        SEGLIN_APPLY_COEFFS, SHORT_STROKE, INVERT_OUTPUT, POST_LIN_DIRECTION, SEGLIN_ENABLE,
        HARMONIC_LIN_ENABLE, PRE_LIN_DIRECTION, FILTER_ENABLE};

    adcr_regs #(.W(16)) uut (.*);

    // Core clock with a 4 ns period.
    always #2 CLK = ~CLK;

    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Each strobe stands for one sampling edge.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WR <= 1'b1;
        @(posedge CLK);
        REG_WR <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        @(posedge CLK);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge CLK);
        REG_RD <= 1'b0;
        #1;
        chk(REG_RVALID, 1'b1);
        chk(REG_RDATA, exp);
    endtask

    // Writes the enable word and waits for the control outputs.
    task automatic alg(input logic [31:0] d);
        wr(`ADCR_ADDR_ALG, d);
        @(posedge CLK);
        #1;
    endtask

    task automatic nvm(input logic v);
        @(posedge CLK);
        {NVM_SEGLIN_REFERENCE_SELECT, NVM_SEGLIN_COEFF_BYPASS, NVM_SHORT_STROKE} <= {3{v}};
        {NVM_INVERT_OUTPUT, NVM_POST_LIN_DIRECTION, NVM_PRE_LIN_DIRECTION} <= {3{v}};
        NVM_LOAD <= 1'b1;
        @(posedge CLK);
        NVM_LOAD <= 1'b0;
    endtask

    task automatic lim(input bit f, input logic [15:0] v, input logic hi, input logic lo);
        @(posedge CLK);
        {ANGLE_UNCLAMPED, FIELD_STRENGTH} <= {v, v};
        {ANGLE_VALID, FIELD_VALID} <= {!f, f};
        @(posedge CLK);
        {ANGLE_VALID, FIELD_VALID} <= 2'b00;
        @(posedge CLK);
        #1;
        chk({ANGLE_HIGH_FLAG, ANGLE_LOW_FLAG, FIELD_HIGH_FLAG, FIELD_LOW_FLAG},
            f ? {2'b00, hi, lo} : {hi, lo, 2'b00});
    endtask

    task automatic tst(input logic to, input logic [15:0] n, input logic f);
        @(posedge CLK);
        SELFTEST_TIMEOUT <= to;
        SELFTEST_FAIL_COUNT <= n;
        SELFTEST_DONE <= 1'b1;
        @(posedge CLK);
        SELFTEST_DONE <= 1'b0;
        #1;
        chk(SELFTEST_FAULT_FLAG, f);
    endtask

    task automatic fc(input logic [31:0] w, input logic [15:0] x, input logic [15:0] exp);
        alg(w);
        @(posedge CLK);
        POST_LIN_ANGLE <= x;
        POST_LIN_VALID <= 1'b1;
        @(posedge CLK);
        POST_LIN_VALID <= 1'b0;
        @(posedge CLK);
        #1;
        chk({FINAL_VALID, FINAL_ANGLE}, {1'b1, exp});
    endtask

    // Segments of 22.5 degrees are 65536 / 16 = 4096 counts wide.
    task automatic sg(input logic [31:0] w, input logic [15:0] a, input logic v);
        alg(w);
        @(posedge CLK);
        LIN_IN_ANGLE <= a;
        LIN_IN_VALID <= 1'b1;
        @(posedge CLK);
        LIN_IN_VALID <= 1'b0;
        #1;
        chk({SEGMENT_VALID, SEGMENT_INDEX}, {v, 4'(a / 16'd4096)});
    endtask

    task automatic t_regs;
        rdc(`ADCR_ADDR_ANGLE_CAP, 32'h0);
        rdc(`ADCR_ADDR_DIAG, 32'h0);
        rdc(`ADCR_ADDR_ALG, 32'h0);
        wr(`ADCR_ADDR_ALG, 32'hffffffff);
        rdc(`ADCR_ADDR_ALG, 32'h0f7fffff);
        wr(8'h07, 32'h12345678);
        rdc(8'h07, 32'h0);
        wr(`ADCR_ADDR_DIAG, 32'hbeef1234);
        rdc(`ADCR_ADDR_DIAG, 32'hbeef1234);
        alg(32'h0f7f1234);
        chk(ctl, 11'h77f);
        chk(OUTPUT_ZERO_SHIFT, 16'h1234);
        alg(32'h01100000);
        chk(ctl, 11'h1c8);
        alg(32'h02100000);
        chk(ctl, 11'h108);
        alg(32'h04000000);
        chk(ctl, 11'h200);
        $display("t_regs done");
    endtask

    task automatic t_nvm;
        wr(`ADCR_ADDR_ALG, 32'h0);
        nvm(1'b1);
        rdc(`ADCR_ADDR_ALG, 32'h07640000);
        wr(`ADCR_ADDR_ALG, 32'h0f7fffff);
        nvm(1'b0);
        rdc(`ADCR_ADDR_ALG, 32'h081bffff);
        chk(ctl, 11'h58d);
        wr(`ADCR_ADDR_ALG, 32'h0);
        rdc(`ADCR_ADDR_ALG, 32'h0);
        $display("t_nvm done");
    endtask

    // Sample just over and just under each limit, and exactly on all but the field lower one.
    task automatic t_limits;
        @(posedge CLK);
        ANGLE_UPPER_LIMIT <= 16'hc000;
        ANGLE_LOWER_LIMIT <= 16'h1000;
        FIELD_UPPER_LIMIT <= 16'h8000;
        FIELD_LOWER_LIMIT <= 16'h0100;
        alg(32'h01000000);
        lim(0, 16'hc001, 1'b1, 1'b0);
        rdc(`ADCR_ADDR_ANGLE_CAP, 32'h0000c001);
        lim(0, 16'h0fff, 1'b0, 1'b1);
        lim(0, 16'hc000, 1'b0, 1'b0);
        lim(0, 16'h1000, 1'b0, 1'b0);
        rdc(`ADCR_ADDR_ANGLE_CAP, 32'h00000fff);
        alg(32'h0);
        lim(0, 16'hffff, 1'b0, 1'b0);
        rdc(`ADCR_ADDR_ANGLE_CAP, 32'h00000fff);
        lim(1, 16'h8001, 1'b1, 1'b0);
        rdc(`ADCR_ADDR_DIAG, 32'hbeef8001);
        lim(1, 16'h00ff, 1'b0, 1'b1);
        lim(1, 16'h8000, 1'b0, 1'b0);
        rdc(`ADCR_ADDR_DIAG, 32'hbeef00ff);
        $display("t_limits done");
    endtask

    task automatic t_selftest;
        tst(1'b0, 16'h0003, 1'b1);
        rdc(`ADCR_ADDR_DIAG, 32'h000300ff);
        tst(1'b1, 16'h0005, 1'b1);
        rdc(`ADCR_ADDR_DIAG, 32'h00ff00ff);
        tst(1'b0, 16'h0000, 1'b0);
        rdc(`ADCR_ADDR_DIAG, 32'h000000ff);
        wr(`ADCR_ADDR_DIAG, 32'h0);
        rdc(`ADCR_ADDR_DIAG, 32'h0);
        $display("t_selftest done");
    endtask

    task automatic t_path;
        @(posedge CLK);
        CLAMP_UPPER <= 16'hf000;
        fc(32'h0, 16'h4321, 16'h4321);
        fc(32'h08000000, 16'h1234, 16'h9234);
        fc(32'h08000000, 16'h9000, 16'h1000);
        fc(32'h00200000, 16'h0001, 16'hffff);
        fc(32'h00400000, 16'h1000, 16'he000);
        fc(32'h08600000, 16'h0010, 16'h7010);
        sg(32'h00100000, 16'ha123, 1'b1);
        sg(32'h00100000, 16'h1000, 1'b1);
        sg(32'h00100000, 16'h0fff, 1'b1);
        sg(32'h0, 16'h5fff, 1'b0);
        $display("t_path done");
    endtask

    // Eight reset cycles, then the scenarios.
    initial begin
        CLK = 1'b0;
        RST_N = 1'b0;
        {REG_ADDR, REG_WR, REG_WDATA, REG_RD, NVM_LOAD, ANGLE_VALID, FIELD_VALID} = '0;
        {NVM_SEGLIN_REFERENCE_SELECT, NVM_SEGLIN_COEFF_BYPASS, NVM_SHORT_STROKE} = '0;
        {NVM_INVERT_OUTPUT, NVM_POST_LIN_DIRECTION, NVM_PRE_LIN_DIRECTION} = '0;
        {ANGLE_UPPER_LIMIT, ANGLE_LOWER_LIMIT, CLAMP_UPPER, FIELD_UPPER_LIMIT} = '0;
        {FIELD_LOWER_LIMIT, ANGLE_UNCLAMPED, FIELD_STRENGTH, LIN_IN_ANGLE, LIN_IN_VALID} = '0;
        {POST_LIN_VALID, POST_LIN_ANGLE, SELFTEST_DONE, SELFTEST_TIMEOUT, SELFTEST_FAIL_COUNT} = '0;
        repeat (8) @(posedge CLK);
        RST_N <= 1'b1;
        t_regs;
        t_nvm;
        t_limits;
        t_selftest;
        t_path;
        wrap_up;
    end

    // Far beyond the run's length; cuts a hang short.
    initial begin
        #20000;
        err_count++;
        wrap_up;
    end
endmodule // adcr_regs_tb_top

`default_nettype wire
